// [common/tick_pkg.sv]
// shared constants for the periodic tick unit
package tick_pkg;

	// ------------------------------------------------------------
	// bus geometry and responses
	// ------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_MASK = 4'h8;

	// ------------------------------------------------------------
	// timebase_control field positions and reset
	// ------------------------------------------------------------
	localparam int ON_BIT = 1;
	localparam int IE_BIT = 2;
	localparam int ACK_BIT = 3;
	localparam int RATE_LSB = 4;
	localparam int RATE_MSB = 6;
	localparam int PEND_BIT = 7;
	localparam logic [2:0] RATE_RESET = 3'h0;

	// ------------------------------------------------------------
	// interrupt status layout
	// ------------------------------------------------------------
	localparam int STAT_W = 2;
	localparam int STAT_TICK = 0;
	localparam int STAT_REFUSED = 1;
	localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

	// ------------------------------------------------------------
	// divider chain
	// ------------------------------------------------------------
	localparam int CHAIN_STAGES = 15;
	localparam int PRE_DIV = 128;
	localparam int PRE_W = 7;

	// tap stage for each rate code; rising edge of stage n
	function automatic logic [3:0] tap_index(input logic [2:0] code);
		unique case (code)
			3'h0: tap_index = 4'hE;
			3'h1: tap_index = 4'hC;
			3'h2: tap_index = 4'hA;
			3'h3: tap_index = 4'h6;
			3'h4: tap_index = 4'h5;
			3'h5: tap_index = 4'h4;
			3'h6: tap_index = 4'h3;
			3'h7: tap_index = 4'h2;
		endcase
	endfunction

endpackage

// [hw/level_sync.sv]
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// levels
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			dout <= '0;
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end

endmodule

// [hw/tick_divider.sv]
// optional divide-by-128 prescaler and 15-stage divider chain
`timescale 1ns/1ps
module tick_divider
	import tick_pkg::*;
#(
	parameter int STAGES = tick_pkg::CHAIN_STAGES,
	parameter int PW = tick_pkg::PRE_W
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic enable,
	input wire logic run,
	input wire logic src_pulse,
	input wire logic prescale,
	input wire logic [2:0] rate,
	// state
	output logic [STAGES-1:0] count_ff,
	output logic rollover_ff
);

	logic [PW-1:0] pre_ff;
	logic [STAGES-1:0] nxt_count;
	logic [3:0] tap;
	logic step;

	// ------------------------------------------------------------
	// prescaler
	// ------------------------------------------------------------
	// prescaler also restarts on disable so both rates begin at zero
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			pre_ff <= '0;
		end else if (run && src_pulse && prescale) begin
			pre_ff <= pre_ff + 1'b1;
		end
	end

	always_comb begin
		step = run && src_pulse && (!prescale || (&pre_ff));
		nxt_count = count_ff + 1'b1;
		tap = tap_index(rate);
	end

	// ------------------------------------------------------------
	// chain and tap event
	// ------------------------------------------------------------
	// held at zero
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			count_ff <= '0;
		end else if (step) begin
			count_ff <= nxt_count;
		end
	end

	// rising tap edge
	// half period first, full after
	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			rollover_ff <= 1'b0;
		end else begin
			rollover_ff <= step && nxt_count[tap] && !count_ff[tap];
		end
	end

endmodule

// [hw/periodic_tick_unit.sv]
// periodic tick unit with axi4-lite register slave
//
// Functional notes
// - disabled counter held at zero, restarts
// - tap rollover sets pending flag
// - pending and interrupt enable raise interrupt request
// - writing one to acknowledge clears pending
// - acknowledge bit always reads zero
// - first event half period, then full
// - codes pick taps 32768 down to 8
// - prescale option multiplies dividers by 128
// - oscillator kept in stop keeps counting
// - no oscillator in stop freezes timebase
// - wait mode keeps counting and flagging
// - control register refused in wait, stop
// - reset clears enable and interrupt enable
// - fifteen stages, eight selectable taps
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module periodic_tick_unit
	import tick_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [tick_pkg::ADDR_W-1:0] awaddr,
	// write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [tick_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	// write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [tick_pkg::ADDR_W-1:0] araddr,
	// read data
	output logic rvalid,
	input wire logic rready,
	output logic [tick_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	// oscillator and system pins
	input wire logic oscillator_clock,
	input wire logic prescale_128_option,
	input wire logic osc_run_in_stop,
	input wire logic wait_mode,
	input wire logic stop_mode,
	// interrupt
	output logic irq
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [4:0] pins_s;
	logic osc_s, pre_s, oscstop_s, wait_s, stop_s;
	logic osc_q_ff;
	logic src_pulse, run, low_power;
	logic tick_enable_ff, tick_irq_enable_ff, tick_pending_flag_ff;
	logic [2:0] tick_rate_select_ff;
	logic [STAT_W-1:0] status_ff, mask_ff;
	logic [CHAIN_STAGES-1:0] chain_count;
	logic rollover;
	logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic aw_got_ff, w_got_ff;
	logic [ADDR_W-1:0] waddr_ff;
	logic [7:0] wbyte_ff;
	logic wstrb0_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic irq_ff;
	logic wr_fire, rd_fire, wr_is_ctrl, wr_ctrl, wr_refused, ack;
	logic [ADDR_W-1:0] waligned, raligned;

	assign awready = awready_ff;
	assign wready = wready_ff;
	assign bvalid = bvalid_ff;
	assign bresp = bresp_ff;
	assign arready = arready_ff;
	assign rvalid = rvalid_ff;
	assign rdata = rdata_ff;
	assign rresp = rresp_ff;
	assign irq = irq_ff;

	// ------------------------------------------------------------
	// pin synchronisers and source edge
	// ------------------------------------------------------------
	level_sync #(.WIDTH(5)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({stop_mode, wait_mode, osc_run_in_stop,
			prescale_128_option, oscillator_clock}),
		.dout(pins_s)
	);
	assign {stop_s, wait_s, oscstop_s, pre_s, osc_s} = pins_s;

	// oscillator must run below half of aclk for edges to be seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_q_ff <= 1'b0;
		end else begin
			osc_q_ff <= osc_s;
		end
	end

	always_comb begin
		src_pulse = osc_s && !osc_q_ff;
		run = !(stop_s && !oscstop_s);
		low_power = wait_s || stop_s;
	end

	// ------------------------------------------------------------
	// divider chain
	// ------------------------------------------------------------
	// tap and prescale
	tick_divider #(.STAGES(CHAIN_STAGES), .PW(PRE_W)) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(tick_enable_ff),
		.run(run),
		.src_pulse(src_pulse),
		.prescale(pre_s),
		.rate(tick_rate_select_ff),
		.count_ff(chain_count),
		.rollover_ff(rollover)
	);

	// ------------------------------------------------------------
	// write channels
	// ------------------------------------------------------------
	always_comb begin
		wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
		rd_fire = arvalid && arready_ff;
		waligned = {waddr_ff[ADDR_W-1:2], 2'h0};
		raligned = {araddr[ADDR_W-1:2], 2'h0};
		wr_is_ctrl = wr_fire && (waligned == OFF_CTRL);
		wr_refused = wr_is_ctrl && low_power;
		wr_ctrl = wr_is_ctrl && !low_power && wstrb0_ff;
		ack = wr_ctrl && wbyte_ff[ACK_BIT];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			aw_got_ff <= 1'b0;
			waddr_ff <= '0;
		end else if (awvalid && awready_ff) begin
			awready_ff <= 1'b0;
			aw_got_ff <= 1'b1;
			waddr_ff <= awaddr;
		end else if (wr_fire) begin
			aw_got_ff <= 1'b0;
		end else if (bvalid_ff && bready) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_ff <= 1'b1;
			w_got_ff <= 1'b0;
			wbyte_ff <= 8'h00;
			wstrb0_ff <= 1'b0;
		end else if (wvalid && wready_ff) begin
			wready_ff <= 1'b0;
			w_got_ff <= 1'b1;
			wbyte_ff <= wdata[7:0];
			wstrb0_ff <= wstrb[0];
		end else if (wr_fire) begin
			w_got_ff <= 1'b0;
		end else if (bvalid_ff && bready) begin
			wready_ff <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			if (wr_refused) begin
				bresp_ff <= RESP_SLVERR;
			end else if (waligned == OFF_CTRL || waligned == OFF_STATUS ||
				waligned == OFF_MASK) begin
				bresp_ff <= RESP_OKAY;
			end else begin
				bresp_ff <= RESP_DECERR;
			end
		end else if (bvalid_ff && bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// timebase control
	// ------------------------------------------------------------
	// reset clears enables
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_enable_ff <= 1'b0;
			tick_irq_enable_ff <= 1'b0;
			tick_rate_select_ff <= RATE_RESET;
		end else if (wr_ctrl) begin
			tick_enable_ff <= wbyte_ff[ON_BIT];
			tick_irq_enable_ff <= wbyte_ff[IE_BIT];
			tick_rate_select_ff <= wbyte_ff[RATE_MSB:RATE_LSB];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_pending_flag_ff <= 1'b0;
		end else begin
			tick_pending_flag_ff <= rollover || (tick_pending_flag_ff && !ack);
		end
	end

	// ------------------------------------------------------------
	// interrupt status, mask and output
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_ff <= STAT_RESET;
			mask_ff <= STAT_RESET;
		end else begin
			// event set wins over the write-one clear
			if (wr_fire && wstrb0_ff && waligned == OFF_STATUS) begin
				status_ff <= status_ff & ~wbyte_ff[STAT_W-1:0];
			end
			if (rollover) begin
				status_ff[STAT_TICK] <= 1'b1;
			end
			if (wr_refused) begin
				status_ff[STAT_REFUSED] <= 1'b1;
			end
			if (wr_fire && wstrb0_ff && waligned == OFF_MASK) begin
				mask_ff <= wbyte_ff[STAT_W-1:0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= (tick_pending_flag_ff && tick_irq_enable_ff) ||
				(|(status_ff & mask_ff));
		end
	end

	// ------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else if (rd_fire) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b1;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
			unique case (raligned)
				OFF_CTRL: begin
					if (low_power) begin
						rresp_ff <= RESP_SLVERR;
					end else begin
						rdata_ff[PEND_BIT] <= tick_pending_flag_ff;
						rdata_ff[RATE_MSB:RATE_LSB] <= tick_rate_select_ff;
						rdata_ff[IE_BIT] <= tick_irq_enable_ff;
						rdata_ff[ON_BIT] <= tick_enable_ff;
					end
				end
				OFF_STATUS: rdata_ff[STAT_W-1:0] <= status_ff;
				OFF_MASK: rdata_ff[STAT_W-1:0] <= mask_ff;
				default: rresp_ff <= RESP_DECERR;
			endcase
		end else if (rvalid_ff && rready) begin
			rvalid_ff <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	logic [CHAIN_STAGES-1:0] low_bits;
	logic [3:0] tap_now;
	always_comb begin
		tap_now = tap_index(tick_rate_select_ff);
		low_bits = chain_count & ~({CHAIN_STAGES{1'b1}} << tap_now);
	end

	sequence s_ctrl_write;
		wr_ctrl;
	endsequence
	sequence s_refused_write;
		wr_refused;
	endsequence

	property p_hold_zero;
		@(posedge aclk) disable iff (!aresetn)
		!tick_enable_ff |=> chain_count == '0;
	endproperty
	a_hold_zero: assert property (p_hold_zero)
		else $error("chain not zero while disabled");

	property p_flag_set;
		@(posedge aclk) disable iff (!aresetn)
		rollover |=> tick_pending_flag_ff && status_ff[STAT_TICK];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("rollover did not set pending");

	property p_irq_req;
		@(posedge aclk) disable iff (!aresetn)
		tick_pending_flag_ff && tick_irq_enable_ff |=> irq_ff;
	endproperty
	a_irq_req: assert property (p_irq_req)
		else $error("interrupt not raised");

	property p_ack_clear;
		@(posedge aclk) disable iff (!aresetn)
		s_ctrl_write ##0 (ack && !rollover) |=> !tick_pending_flag_ff;
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("acknowledge did not clear pending");

	property p_ack_zero;
		@(posedge aclk) disable iff (!aresetn)
		rvalid_ff |-> !rdata_ff[ACK_BIT];
	endproperty
	a_ack_zero: assert property (p_ack_zero)
		else $error("acknowledge bit read as one");

	property p_tap_event;
		@(posedge aclk) disable iff (!aresetn)
		rollover |-> chain_count[tap_now] && low_bits == '0;
	endproperty
	a_tap_event: assert property (p_tap_event)
		else $error("rollover off the selected tap");

	property p_stop_freeze;
		@(posedge aclk) disable iff (!aresetn)
		(stop_s && !oscstop_s && tick_enable_ff) ##1 tick_enable_ff
			|-> $stable(chain_count);
	endproperty
	a_stop_freeze: assert property (p_stop_freeze)
		else $error("chain moved in stop without oscillator");

	property p_refused;
		@(posedge aclk) disable iff (!aresetn)
		s_refused_write |=> bvalid_ff && bresp_ff == RESP_SLVERR &&
			$stable(tick_enable_ff) && $stable(tick_rate_select_ff);
	endproperty
	a_refused: assert property (p_refused)
		else $error("control written in low power");

	property p_reset_clear;
		@(posedge aclk)
		!aresetn |=> !tick_enable_ff && !tick_irq_enable_ff && !irq_ff;
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("enables not cleared by reset");

	property p_set_wins;
		@(posedge aclk) disable iff (!aresetn)
		rollover && ack |=> tick_pending_flag_ff;
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost to acknowledge");

endmodule

// [dv/periodic_tick_unit_bench.sv]
// self-checking bench for the periodic tick unit
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module periodic_tick_unit_bench;
	import tick_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
	logic [DATA_W-1:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic oscillator_clock = 1'b0, prescale_128_option = 1'b0;
	logic osc_run_in_stop = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0;
	logic [1:0] oc = 2'h0;
	int cyc = 0;
	int bad_count = 0;
	int total_checks = 0;
	int divs[8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};
	periodic_tick_unit u_dut (.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.oscillator_clock(oscillator_clock),
		.prescale_128_option(prescale_128_option),
		.osc_run_in_stop(osc_run_in_stop), .wait_mode(wait_mode),
		.stop_mode(stop_mode), .irq(irq));
	initial begin
		forever #20 aclk = ~aclk;
	end
	// source clock of four aclk periods, free running
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		oc <= oc + 2'h1;
		oscillator_clock <= oc[1];
	end
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	// waits as long as the answer takes; only the watchdog ends a hang
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	function automatic logic [31:0] ctl(int c, logic ie, logic on, logic ack);
		ctl = (32'(c) << RATE_LSB) | (32'(ack) << ACK_BIT) |
			(32'(ie) << IE_BIT) | (32'(on) << ON_BIT);
	endfunction
	task automatic clr;
		logic [1:0] r;
		wr(OFF_STATUS, 32'h3, r);
	endtask
	// irq rise after it has been low; cycle stamp returned
	// an event may beat the clear, so clear again until irq drops
	task automatic rise(output int t);
		while (irq !== 1'b0) begin
			clr;
			@(posedge aclk);
		end
		while (irq !== 1'b1) @(posedge aclk);
		t = cyc;
	endtask
	task automatic period(input int p);
		int t1, t2;
		rise(t1);
		rise(t2);
		`CHK(t2 - t1, p)
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		`CHK(irq, 1'b0)
		`CHK({awready, wready, arready, bvalid, rvalid}, 5'h1C)
		rd(OFF_CTRL, d, r);
		`CHK(d, 32'h0)
		rd(OFF_STATUS, d, r);
		`CHK(d, 32'h0)
		rd(OFF_MASK, d, r);
		`CHK(d, 32'h0)
		$display("done reset");
	endtask
	task automatic t_rates(input int lo, input int mul);
		logic [31:0] d;
		logic [1:0] r;
		int p, t0, t1;
		wr(OFF_MASK, 32'h1, r);
		for (int c = 7; c >= lo; c--) begin
			p = divs[c] * 4 * mul;
			// rate changed only while disabled
			wr(OFF_CTRL, 32'h0, r);
			clr;
			wr(OFF_CTRL, ctl(c, 1'b0, 1'b1, 1'b0), r);
			t0 = cyc;
			rd(OFF_CTRL, d, r);
			`CHK(d & 32'h7F, ctl(c, 1'b0, 1'b1, 1'b0))
			rise(t1);
			t1 -= t0;
			`CHK(t1 >= p / 2 - 4 && t1 <= p / 2 + 16, 1'b1)
			period(p);
		end
		$display("done rates");
	endtask
	task automatic t_prescale;
		prescale_128_option <= 1'b1;
		t_rates(7, 128);
		@(posedge aclk);
		prescale_128_option <= 1'b0;
		$display("done prescale");
	endtask
	task automatic t_ack;
		logic [31:0] d;
		logic [1:0] r;
		int t;
		wr(OFF_MASK, 32'h0, r);
		// restart from zero so no event can meet the first acknowledge
		wr(OFF_CTRL, 32'h0, r);
		wr(OFF_CTRL, ctl(7, 1'b1, 1'b1, 1'b1), r);
		rise(t);
		wr(OFF_CTRL, ctl(7, 1'b1, 1'b1, 1'b0), r);
		rd(OFF_CTRL, d, r);
		`CHK(d[PEND_BIT], 1'b1)
		`CHK(irq, 1'b1)
		wr(OFF_CTRL, ctl(7, 1'b1, 1'b1, 1'b1), r);
		rd(OFF_CTRL, d, r);
		`CHK(d[PEND_BIT], 1'b0)
		`CHK(d[ACK_BIT], 1'b0)
		`CHK(irq, 1'b0)
		wr(OFF_CTRL, ctl(7, 1'b0, 1'b1, 1'b0), r);
		repeat (80) @(posedge aclk);
		rd(OFF_CTRL, d, r);
		`CHK(d[PEND_BIT], 1'b1)
		`CHK(irq, 1'b0)
		$display("done ack");
	endtask
	task automatic t_disable;
		logic [31:0] d;
		logic [1:0] r;
		// timebase off before a quiet wait, no events expected
		wr(OFF_CTRL, 32'h0, r);
		clr;
		wait_mode <= 1'b1;
		repeat (300) @(posedge aclk);
		wait_mode <= 1'b0;
		repeat (4) @(posedge aclk);
		rd(OFF_STATUS, d, r);
		`CHK(d[STAT_TICK], 1'b0)
		`CHK(irq, 1'b0)
		$display("done disable");
	endtask
	task automatic t_low_power;
		logic [31:0] d;
		logic [1:0] r;
		wr(OFF_MASK, 32'h1, r);
		wr(OFF_CTRL, ctl(7, 1'b0, 1'b1, 1'b0), r);
		wait_mode <= 1'b1;
		repeat (4) @(posedge aclk);
		wr(OFF_CTRL, 32'h0, r);
		`CHK(r, RESP_SLVERR)
		rd(OFF_CTRL, d, r);
		`CHK(r, RESP_SLVERR)
		`CHK(d, 32'h0)
		rd(OFF_STATUS, d, r);
		`CHK(d[STAT_REFUSED], 1'b1)
		period(32);
		wait_mode <= 1'b0;
		stop_mode <= 1'b1;
		osc_run_in_stop <= 1'b1;
		repeat (4) @(posedge aclk);
		period(32);
		osc_run_in_stop <= 1'b0;
		repeat (4) @(posedge aclk);
		clr;
		repeat (300) @(posedge aclk);
		rd(OFF_STATUS, d, r);
		`CHK(d[STAT_TICK], 1'b0)
		`CHK(irq, 1'b0)
		stop_mode <= 1'b0;
		repeat (4) @(posedge aclk);
		$display("done low power");
	endtask
	task automatic t_unmapped;
		logic [31:0] d;
		logic [1:0] r;
		wr(4'hC, 32'hFF, r);
		`CHK(r, RESP_DECERR)
		rd(4'hC, d, r);
		`CHK(r, RESP_DECERR)
		`CHK(d, 32'h0)
		// byte lane 0 off: answered but nothing changes
		wstrb <= 4'h0;
		wr(OFF_MASK, 32'h2, r);
		`CHK(r, RESP_OKAY)
		wstrb <= 4'hF;
		rd(OFF_MASK, d, r);
		`CHK(d, 32'h1)
		$display("done unmapped");
	endtask
	// ------------------------------------------------------------
	// sequence and verdict
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		// tests need about 36000 cycles, mostly the slow rate codes
		#(40 * 60000);
		bad_count++;
		results;
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_rates(2, 1);
		t_prescale;
		t_ack;
		t_disable;
		t_low_power;
		t_unmapped;
		results;
	end
endmodule
